// [src/tla_pkg.sv]
package tla_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_L2_FLAGS = 8'h17;
    localparam logic [7:0] IDX_L1_FLAGS = 8'h18;
    localparam logic [7:0] IDX_L0_FLAGS = 8'h19;
    localparam logic [7:0] IDX_L2_MASKS = 8'h1a;
    localparam logic [7:0] IDX_L1_MASKS = 8'h1b;
    localparam logic [7:0] IDX_L0_MASKS = 8'h1c;
    localparam logic [7:0] IDX_CORE_STATUS = 8'h1d;

    // Reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASKS_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Core status field positions
    localparam int ST_LEVEL2_ENABLE = 7;
    localparam int ST_LEVEL1_ENABLE = 6;
    localparam int ST_GLOBAL_ENABLE = 5;
    localparam int ST_PENDING_LSB = 2;
    localparam int ST_EVENT_LSB = 0;

    // Program memory vectors
    localparam logic [1:0] VEC_START = 2'h0;
    localparam logic [1:0] VEC_LEVEL1 = 2'h1;
    localparam logic [1:0] VEC_LEVEL2 = 2'h2;
    localparam logic [1:0] VEC_LEVEL0 = 2'h3;

    // Return stack levels
    localparam logic [2:0] STACK_LEVELS = 3'h4;

    // Cycles a status write to the event bits lags behind the bus access
    localparam int EVENT_WRITE_DELAY = 2;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } tla_apb_req_t;

    typedef struct packed {
        logic [1:0] dualPortRamRequest;
        logic [1:0] serialPortRequest;
        logic timer4Request;
        logic timer3Request;
        logic timer2Request;
        logic timer1Request;
        logic [7:0] portARequests;
        logic [2:0] prescaler1Taps;
        logic programMemorySkipRequest;
    } tla_sources_t;

    typedef enum logic [1:0] {
        TAKE_IDLE = 2'b01,
        TAKE_CALL = 2'b10
    } tla_take_state_t;

endpackage

// [src/tla_irq_acquisition.sv]
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module tla_irq_acquisition (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic coreReset,
    input wire tla_pkg::tla_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tla_pkg::tla_sources_t sources,
    input wire logic debouncedWakeup,
    input wire logic takeAck,
    input wire logic subroutineCallOp,
    input wire logic subroutineExitOp,
    input wire logic irqExitOp,
    output logic takeReq,
    output logic [1:0] vectorAddr,
    output logic [2:0] coreRequest,
    output logic [7:0] coreStatus,
    output logic haltDisable,
    output logic stackFull
);

    localparam int EVD = tla_pkg::EVENT_WRITE_DELAY;
    logic rstMeta_n, rstSync_n;
    logic [7:0] srcVec [3], flagReg [3], maskReg [3], setVec [3];
    logic [2:0] hitFlag, hitMask;
    logic hitStatus, mapped, addrOk;
    logic [7:0] regIdx, readMux;
    logic setupPhase, accessDone, wrDone, rdDone, statusWr;
    logic [31:0] prdataReg;
    logic gieReg, push, pop, takeStart;
    logic [1:0] levelEnReg, eventReg, eventNext, vectorReg;
    logic [2:0] pendingReg, pendingDlyReg, pendingNext, latchSet, levelOk, eligible, depthReg;
    logic [EVD-1:0] evPipeValid;
    logic [1:0] evPipeData [EVD];
    tla_pkg::tla_take_state_t stateReg;

    // Reset release through two flops; assert stays asynchronous
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // Source routing per branch
    // level 0, 1 and 2 mapping
    assign srcVec[0] = {4'h0, sources.prescaler1Taps, sources.programMemorySkipRequest};
    assign srcVec[1] = sources.portARequests;
    assign srcVec[2] = {sources.dualPortRamRequest, sources.serialPortRequest,
                        sources.timer4Request, sources.timer3Request,
                        sources.timer2Request, sources.timer1Request};

    // Bus phases; slave answers in the first access cycle
    assign regIdx = apbReq.paddr[9:2];
    assign addrOk = (apbReq.paddr[31:10] == 22'h0) && (apbReq.paddr[1:0] == 2'h0);
    assign setupPhase = apbReq.psel && !apbReq.penable;
    assign accessDone = apbReq.psel && apbReq.penable;
    assign wrDone = accessDone && apbReq.pwrite && mapped;
    assign rdDone = accessDone && !apbReq.pwrite && mapped;
    assign statusWr = wrDone && hitStatus;
    assign pready = accessDone;
    assign pslverr = accessDone && !mapped;
    assign prdata = prdataReg;

    // Address decode
    always_comb begin
        hitFlag = 3'h0;
        hitMask = 3'h0;
        hitStatus = 1'b0;
        if (!addrOk) begin
            hitStatus = 1'b0;
        end else if (regIdx == tla_pkg::IDX_L0_FLAGS) begin
            hitFlag[0] = 1'b1;
        end else if (regIdx == tla_pkg::IDX_L1_FLAGS) begin
            hitFlag[1] = 1'b1;
        end else if (regIdx == tla_pkg::IDX_L2_FLAGS) begin
            hitFlag[2] = 1'b1;
        end else if (regIdx == tla_pkg::IDX_L0_MASKS) begin
            hitMask[0] = 1'b1;
        end else if (regIdx == tla_pkg::IDX_L1_MASKS) begin
            hitMask[1] = 1'b1;
        end else if (regIdx == tla_pkg::IDX_L2_MASKS) begin
            hitMask[2] = 1'b1;
        end else if (regIdx == tla_pkg::IDX_CORE_STATUS) begin
            hitStatus = 1'b1;
        end
        mapped = (|hitFlag) || (|hitMask) || hitStatus;
    end

    // Read data mux
    always_comb begin
        readMux = 8'h00;
        for (int k = 0; k < 3; k++) begin
            if (hitFlag[k]) begin
                readMux = flagReg[k];
            end
            if (hitMask[k]) begin
                readMux = maskReg[k];
            end
        end
        if (hitStatus) begin
            readMux = coreStatus;
        end
    end

    // Read data sampled at setup, so the cleared bits equal the reported ones
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            prdataReg <= 32'h0;
        end else if (setupPhase && !apbReq.pwrite) begin
            prdataReg <= {24'h0, readMux};
        end
    end

    // One acquisition branch per priority level
    // separate state per branch
    for (genvar g = 0; g < 3; g++) begin : gBranch
        logic [7:0] srcPrev, clrVec;
        assign setVec[g] = srcVec[g] & ~srcPrev & maskReg[g];
        // read clears reported bits; zero written clears
        assign clrVec = ((rdDone && hitFlag[g]) ? prdataReg[7:0] : 8'h00)
                      | ((wrDone && hitFlag[g]) ? ~apbReq.pwdata[7:0] : 8'h00);
        assign coreRequest[g] = |flagReg[g];

        // Edge history
        always_ff @(posedge ref_clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                srcPrev <= 8'h00;
            end else begin
                srcPrev <= srcVec[g];
            end
        end

        // reset clear; set beats clear; mask gates the set only
        always_ff @(posedge ref_clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                flagReg[g] <= tla_pkg::FLAGS_RESET;
            end else if (coreReset) begin
                flagReg[g] <= tla_pkg::FLAGS_RESET;
            end else begin
                flagReg[g] <= (flagReg[g] & ~clrVec) | setVec[g];
            end
        end

        always_ff @(posedge ref_clk or negedge rstSync_n) begin
            if (!rstSync_n) begin
                maskReg[g] <= tla_pkg::MASKS_RESET;
            end else if (coreReset) begin
                maskReg[g] <= tla_pkg::MASKS_RESET;
            end else if (wrDone && hitMask[g]) begin
                maskReg[g] <= apbReq.pwdata[7:0];
            end
        end

        mask_block_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
            (!maskReg[g][0] && !flagReg[g][0] && !coreReset) |=> !flagReg[g][0])
            else $error("masked source set its flag");
        // zero written bits end clear unless a new edge came
        write_clear_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
            (wrDone && hitFlag[g])
            |=> ((flagReg[g] & ~$past(apbReq.pwdata[7:0]) & ~$past(setVec[g])) == 8'h00))
            else $error("flag survived zero write");
        // reported bits gone unless a new edge came
        read_clear_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
            (rdDone && hitFlag[g] && !coreReset)
            |=> ((flagReg[g] & $past(prdataReg[7:0])) == ($past(setVec[g]) & $past(prdataReg[7:0]))))
            else $error("read did not clear reported flags");
    end

    // Core status image
    // bit layout
    assign coreStatus = {levelEnReg[1], levelEnReg[0], gieReg, pendingReg, eventReg};

    // Level gating: level 0 has no own enable
    // per level enable
    assign levelOk = {levelEnReg[1], levelEnReg[0], 1'b1};
    assign latchSet = coreRequest & levelOk & {3{gieReg && !stackFull}};

    // Level enables
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            levelEnReg <= 2'h0;
        end else if (coreReset) begin
            levelEnReg <= 2'h0;
        end else if (statusWr) begin
            levelEnReg <= apbReq.pwdata[tla_pkg::ST_LEVEL2_ENABLE -: 2];
        end
    end

    // Global enable; take clears it ahead of any other source
    // take clears, exit restores; plain return ignored
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            gieReg <= 1'b0;
        end else if (coreReset) begin
            gieReg <= 1'b0;
        end else if (takeStart) begin
            gieReg <= 1'b0;
        end else if (irqExitOp) begin
            gieReg <= 1'b1;
        end else if (statusWr) begin
            gieReg <= apbReq.pwdata[tla_pkg::ST_GLOBAL_ENABLE];
        end
    end

    // Pending latches; software writes, hardware set wins
    // software set and clear; set wins; clear left to software
    always_comb begin
        pendingNext = pendingReg;
        if (statusWr) begin
            pendingNext = apbReq.pwdata[tla_pkg::ST_PENDING_LSB +: 3];
        end
        pendingNext = pendingNext | latchSet;
    end
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pendingReg <= 3'h0;
            pendingDlyReg <= 3'h0;
        end else if (coreReset) begin
            pendingReg <= 3'h0;
            pendingDlyReg <= 3'h0;
        end else begin
            pendingReg <= pendingNext;
            pendingDlyReg <= pendingReg;
        end
    end

    // Event write lags the bus so a following jump on event misses it
    // event write delay
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            evPipeValid <= '0;
            for (int k = 0; k < EVD; k++) begin
                evPipeData[k] <= 2'h0;
            end
        end else begin
            evPipeValid <= {evPipeValid[EVD-2:0], statusWr};
            evPipeData[0] <= apbReq.pwdata[tla_pkg::ST_EVENT_LSB +: 2];
            for (int k = 1; k < EVD; k++) begin
                evPipeData[k] <= evPipeData[k-1];
            end
        end
    end

    // Event latches; event 1 has no hardware source
    // event sources; software set and clear
    assign eventNext = (evPipeValid[EVD-1] ? evPipeData[EVD-1] : eventReg)
                     | {1'b0, debouncedWakeup};
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            eventReg <= 2'h0;
        end else if (coreReset) begin
            eventReg <= 2'h0;
        end else begin
            eventReg <= eventNext;
        end
    end

    // halt held off while anything pends
    assign haltDisable = (|pendingReg) || (|eventReg);
    // Pending must be seen two cycles so one instruction slips in after a trap
    // one instruction before jump; re-entry while pending
    assign eligible = pendingReg & pendingDlyReg & levelOk;
    // no take without global enable; full stack
    assign takeStart = (stateReg == tla_pkg::TAKE_IDLE) && gieReg && !stackFull && (|eligible);
    assign takeReq = (stateReg == tla_pkg::TAKE_CALL);
    assign vectorAddr = vectorReg;

    // Take sequencer
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            stateReg <= tla_pkg::TAKE_IDLE;
        end else if (coreReset) begin
            stateReg <= tla_pkg::TAKE_IDLE;
        end else begin
            case (stateReg)
                tla_pkg::TAKE_IDLE: begin
                    if (takeStart) begin
                        stateReg <= tla_pkg::TAKE_CALL;
                    end
                end
                tla_pkg::TAKE_CALL: begin
                    if (takeAck) begin
                        stateReg <= tla_pkg::TAKE_IDLE;
                    end
                end
                default: begin
                    stateReg <= tla_pkg::TAKE_IDLE;
                end
            endcase
        end
    end

    // Vector choice, level 0 first
    // priority order; vector mapping; start vector
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            vectorReg <= tla_pkg::VEC_START;
        end else if (coreReset) begin
            vectorReg <= tla_pkg::VEC_START;
        end else if (takeStart) begin
            if (eligible[0]) begin
                vectorReg <= tla_pkg::VEC_LEVEL0;
            end else if (eligible[1]) begin
                vectorReg <= tla_pkg::VEC_LEVEL1;
            end else begin
                vectorReg <= tla_pkg::VEC_LEVEL2;
            end
        end
    end

    // Return stack occupancy; overflow beyond four is not tracked
    // return pushed; full detect
    assign push = (takeReq && takeAck) || subroutineCallOp;
    assign pop = irqExitOp || subroutineExitOp;
    assign stackFull = (depthReg == tla_pkg::STACK_LEVELS);
    always_ff @(posedge ref_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            depthReg <= 3'h0;
        end else if (coreReset) begin
            depthReg <= 3'h0;
        end else if (push && !pop && !stackFull) begin
            depthReg <= depthReg + 3'h1;
        end else if (pop && !push && (depthReg != 3'h0)) begin
            depthReg <= depthReg - 3'h1;
        end
    end

    // Checks on the core side
    reset_clear_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        coreReset |=> (maskReg[1] == 8'h00) && (flagReg[2] == 8'h00) && (coreStatus == 8'h00))
        else $error("reset left state behind");
    gie_block_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (!gieReg && !takeReq) |-> !takeStart ##1 !takeReq)
        else $error("take without global enable");
    stack_full_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (depthReg == 3'h4) |-> (!takeStart && (latchSet == 3'h0)))
        else $error("take with full stack");
    take_gie_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (takeStart && !coreReset) |=> (!gieReg && takeReq))
        else $error("global enable kept after take");
    level0_vec_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (takeStart && eligible[0] && !coreReset) |=> (vectorAddr == 2'h3))
        else $error("level 0 vector wrong");
    trap_delay_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (statusWr && pendingReg == 3'h0 && !coreReset) |=> !takeStart)
        else $error("software trap taken without slip");
    ret_keeps_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (subroutineExitOp && !irqExitOp && !takeStart && !statusWr && !coreReset)
        |=> (gieReg == $past(gieReg)))
        else $error("plain return changed global enable");
    halt_hold_a: assert property (@(posedge ref_clk) disable iff (!rstSync_n)
        (debouncedWakeup && !coreReset) |=> haltDisable)
        else $error("halt not disabled by event");

endmodule // tla_irq_acquisition

// [verif/tla_core_model.sv]
`timescale 1ns/1ps
// Core side of the take handshake: fetches the vector after a set wait
module tla_core_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic takeReq,
    input wire logic [1:0] vectorAddr,
    input wire logic [3:0] ackDelay,
    output logic takeAck,
    output logic [1:0] lastVector,
    output logic [7:0] takeCount
);
    logic [3:0] waitCnt;

    // Ack is a single cycle; a slow core leaves the request standing longer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            takeAck <= 1'b0;
            waitCnt <= 4'h0;
            lastVector <= 2'h0;
            takeCount <= 8'h00;
        end else if (takeReq && !takeAck) begin
            if (waitCnt >= ackDelay) begin
                takeAck <= 1'b1;
                lastVector <= vectorAddr;
                takeCount <= takeCount + 8'h01;
                waitCnt <= 4'h0;
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end else begin
            takeAck <= 1'b0;
            waitCnt <= 4'h0;
        end
    end
endmodule // tla_core_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
    logic ref_clk;
    logic rst_n;
    logic coreReset;
    tla_pkg::tla_apb_req_t apbReq;
    tla_pkg::tla_sources_t sources;
    logic debouncedWakeup;
    logic takeAck;
    logic takeReq;
    logic [2:0] opPulse;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] vectorAddr;
    logic [2:0] coreRequest;
    logic [7:0] coreStatus;
    logic haltDisable;
    logic stackFull;
    logic [3:0] ackDelay;
    logic [1:0] lastVector;
    logic [7:0] takeCount;
    logic lastErr;
    int nMismatch;
    int comparisons;

    tla_irq_acquisition u_tla_irq_acquisition (.ref_clk(ref_clk), .rst_n(rst_n),
        .coreReset(coreReset), .apbReq(apbReq), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sources(sources), .debouncedWakeup(debouncedWakeup),
        .takeAck(takeAck), .subroutineCallOp(opPulse[2]), .subroutineExitOp(opPulse[1]),
        .irqExitOp(opPulse[0]), .takeReq(takeReq), .vectorAddr(vectorAddr),
        .coreRequest(coreRequest), .coreStatus(coreStatus), .haltDisable(haltDisable),
        .stackFull(stackFull));

    tla_core_model u_tla_core_model (.ref_clk(ref_clk), .rst_n(rst_n), .takeReq(takeReq),
        .vectorAddr(vectorAddr), .ackDelay(ackDelay), .takeAck(takeAck),
        .lastVector(lastVector), .takeCount(takeCount));

    // Free-running 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
        if (nMismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        apbReq.psel <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite <= wr;
        apbReq.paddr <= {22'h0, idx, 2'b00};
        apbReq.pwdata <= {24'h000000, wd};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk8("pready", 8'h01, {7'h00, pready});
            wrap_up();
        end
        rd = prdata[7:0];
        lastErr = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] v;
        apb(1'b0, idx, 8'h00, v);
        chk8(what, exp, v);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] v;
        apb(1'b1, idx, d, v);
    endtask

    // Source lines held high two cycles so the edge detector sees them
    task automatic pulse_src(input logic [19:0] v);
        @(posedge ref_clk);
        sources <= tla_pkg::tla_sources_t'(v);
        repeat (2) @(posedge ref_clk);
        sources <= '0;
    endtask

    task automatic pulse_op(input logic [2:0] v);
        @(posedge ref_clk);
        opPulse <= v;
        @(posedge ref_clk);
        opPulse <= 3'b000;
    endtask

    task automatic wait_take(input logic [1:0] vec);
        logic [7:0] c0;
        int n;
        c0 = takeCount;
        n = 0;
        while (takeCount === c0 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        chk8("take count", c0 + 8'h01, takeCount);
        if (takeCount === c0) begin
            wrap_up();
        end
        chk8("vector", {6'h00, vec}, {6'h00, lastVector});
    endtask

    task automatic no_take(input int k);
        logic [7:0] c0;
        c0 = takeCount;
        repeat (k) @(posedge ref_clk);
        chk8("take count", c0, takeCount);
    endtask

    initial begin
        rst_n = 1'b0;
        coreReset = 1'b0;
        apbReq = '0;
        sources = '0;
        debouncedWakeup = 1'b0;
        opPulse = 3'b000;
        ackDelay = 4'h0;
        nMismatch = 0;
        comparisons = 0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Reset values and an unmapped access
        for (int i = 8'h17; i <= 8'h1d; i++) rd(i[7:0], 8'h00, "reset value");
        rd(8'h20, 8'h00, "unmapped read");
        chk8("unmapped error", 8'h01, {7'h00, lastErr});
        $display("test reset done");
        // Masked sources leave flags alone
        pulse_src(20'hfffff);
        rd(tla_pkg::IDX_L2_FLAGS, 8'h00, "masked l2");
        rd(tla_pkg::IDX_L0_FLAGS, 8'h00, "masked l0");
        wr(tla_pkg::IDX_L2_MASKS, 8'hff);
        wr(tla_pkg::IDX_L1_MASKS, 8'hff);
        wr(tla_pkg::IDX_L0_MASKS, 8'h0f);
        rd(tla_pkg::IDX_L0_MASKS, 8'h0f, "mask readback");
        pulse_src(20'h81a59);
        chk8("core request", 8'h07, {5'h00, coreRequest});
        rd(tla_pkg::IDX_L2_FLAGS, 8'h81, "l2 map");
        rd(tla_pkg::IDX_L1_FLAGS, 8'ha5, "l1 map");
        rd(tla_pkg::IDX_L0_FLAGS, 8'h09, "l0 map");
        rd(tla_pkg::IDX_L2_FLAGS, 8'h00, "read clear");
        chk8("core request", 8'h00, {5'h00, coreRequest});
        pulse_src(20'hf5010);
        wr(tla_pkg::IDX_L2_FLAGS, 8'h0f);
        rd(tla_pkg::IDX_L1_FLAGS, 8'h01, "other branch");
        rd(tla_pkg::IDX_L2_FLAGS, 8'h05, "write clear");
        pulse_src(20'h00100);
        wr(tla_pkg::IDX_L1_MASKS, 8'h00);
        pulse_src(20'h00200);
        rd(tla_pkg::IDX_L1_FLAGS, 8'h10, "mask keeps flag");
        wr(tla_pkg::IDX_L1_MASKS, 8'hff);
        $display("test acquisition done");
        // Software and wake-up events
        wr(tla_pkg::IDX_CORE_STATUS, 8'h03);
        repeat (4) @(posedge ref_clk);
        rd(tla_pkg::IDX_CORE_STATUS, 8'h03, "event set");
        chk8("halt disable", 8'h01, {7'h00, haltDisable});
        wr(tla_pkg::IDX_CORE_STATUS, 8'h00);
        repeat (4) @(posedge ref_clk);
        rd(tla_pkg::IDX_CORE_STATUS, 8'h00, "event clear");
        chk8("halt disable", 8'h00, {7'h00, haltDisable});
        @(posedge ref_clk);
        debouncedWakeup <= 1'b1;
        @(posedge ref_clk);
        debouncedWakeup <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(tla_pkg::IDX_CORE_STATUS, 8'h01, "wakeup event");
        wr(tla_pkg::IDX_CORE_STATUS, 8'h00);
        $display("test events done");
        // Priority, re-entry and no preemption
        pulse_src(20'h01010);
        no_take(6);
        chk8("core request", 8'h06, {5'h00, coreRequest});
        wr(tla_pkg::IDX_CORE_STATUS, 8'he0);
        wait_take(tla_pkg::VEC_LEVEL1);
        rd(tla_pkg::IDX_CORE_STATUS, 8'hd8, "after take");
        rd(tla_pkg::IDX_L1_FLAGS, 8'h01, "l1 handler");
        wr(tla_pkg::IDX_CORE_STATUS, 8'hd0);
        pulse_op(3'b001);
        wait_take(tla_pkg::VEC_LEVEL2);
        pulse_src(20'h00001);
        no_take(8);
        rd(tla_pkg::IDX_L2_FLAGS, 8'h01, "l2 handler");
        wr(tla_pkg::IDX_CORE_STATUS, 8'hc0);
        pulse_op(3'b001);
        wait_take(tla_pkg::VEC_LEVEL0);
        rd(tla_pkg::IDX_L0_FLAGS, 8'h01, "l0 handler");
        wr(tla_pkg::IDX_CORE_STATUS, 8'hc0);
        pulse_op(3'b001);
        repeat (3) @(posedge ref_clk);
        rd(tla_pkg::IDX_CORE_STATUS, 8'he0, "after exit");
        $display("test priority done");
        // Level enables: level 0 needs only the global enable
        wr(tla_pkg::IDX_CORE_STATUS, 8'h20);
        pulse_src(20'h00010);
        no_take(8);
        pulse_src(20'h00001);
        wait_take(tla_pkg::VEC_LEVEL0);
        rd(tla_pkg::IDX_L1_FLAGS, 8'h01, "l1 kept");
        rd(tla_pkg::IDX_L0_FLAGS, 8'h01, "l0 handler");
        wr(tla_pkg::IDX_CORE_STATUS, 8'h00);
        pulse_op(3'b001);
        wr(tla_pkg::IDX_CORE_STATUS, 8'h24);
        wait_take(tla_pkg::VEC_LEVEL0);
        rd(tla_pkg::IDX_CORE_STATUS, 8'h04, "soft trap");
        wr(tla_pkg::IDX_CORE_STATUS, 8'h00);
        pulse_op(3'b001);
        $display("test enables done");
        // Full return stack blocks takes; a slow core answers here
        ackDelay <= 4'h3;
        repeat (4) pulse_op(3'b100);
        @(posedge ref_clk);
        chk8("stack full", 8'h01, {7'h00, stackFull});
        pulse_src(20'h00001);
        no_take(10);
        pulse_op(3'b010);
        wait_take(tla_pkg::VEC_LEVEL0);
        pulse_op(3'b010);
        repeat (3) @(posedge ref_clk);
        rd(tla_pkg::IDX_CORE_STATUS, 8'h04, "plain return");
        $display("test stack done");
        // Core reset clears masks, status and stack
        @(posedge ref_clk);
        coreReset <= 1'b1;
        @(posedge ref_clk);
        coreReset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd(tla_pkg::IDX_L2_MASKS, 8'h00, "mask after reset");
        rd(tla_pkg::IDX_CORE_STATUS, 8'h00, "status after reset");
        chk8("stack full", 8'h00, {7'h00, stackFull});
        chk8("start vector", 8'h00, {6'h00, vectorAddr});
        chk8("status port", 8'h00, coreStatus);
        $display("test core reset done");
        wrap_up();
    end
endmodule // tb
